//--- tlic_cfg.svh
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH
// Register offsets on the plain register port (byte-wide registers)
`define TLIC_ADDR_W 8
`define TLIC_OFS_TIMER_CONTROL_REG 8'h88
`define TLIC_OFS_IE 8'hA8
`define TLIC_OFS_IEA 8'hA7
`define TLIC_OFS_IP 8'hB8
`define TLIC_OFS_IPA 8'hB7
`define TLIC_OFS_TIMER2_CONTROL_REG 8'hC8
`define TLIC_OFS_FLAGS 8'hF0
`define TLIC_OFS_FLCLR 8'hF1
`define TLIC_OFS_CTRL 8'hF2
// Timer control register bit positions
`define TLIC_TIMER_CONTROL_REG_TF1 7
`define TLIC_TIMER_CONTROL_REG_TF0 5
`define TLIC_TIMER_CONTROL_REG_IE1 3
`define TLIC_TIMER_CONTROL_REG_IT1 2
`define TLIC_TIMER_CONTROL_REG_IE0 1
`define TLIC_TIMER_CONTROL_REG_IT0 0
// Timer 2 control register bit positions
`define TLIC_T2_TF2 7
`define TLIC_T2_TIMER2_EXT_EVENT_FLAG 6
`define TLIC_T2_TIMER2_EXT_EVENT_ENABLE 3
// Global enable bit of the enable register
`define TLIC_IE_EA 7
// Flags register (software-cleared source flags) bit positions
`define TLIC_FL_DBG 0
`define TLIC_FL_ADC 1
`define TLIC_FL_TW 2
// Control register: bit 0 is the timer 0 mode 3 indication
`define TLIC_CTRL_T0M3 0
`define TLIC_RST_BYTE 8'h00
// Vector table
`define TLIC_VEC_DBG 16'h0063
`define TLIC_VEC_EX0 16'h0003
`define TLIC_VEC_T0 16'h000B
`define TLIC_VEC_EX1 16'h0013
`define TLIC_VEC_T1 16'h001B
`define TLIC_VEC_U0 16'h0023
`define TLIC_VEC_T2 16'h002B
`define TLIC_VEC_SPI 16'h0053
`define TLIC_VEC_TW 16'h0043
`define TLIC_VEC_ADC 16'h003B
`define TLIC_VEC_PCA 16'h005B
`define TLIC_VEC_U1 16'h004B
`define TLIC_NSRC 12
`endif

//--- tlic_pkg.sv
package tlic_pkg;
  // Source index equals polling order, 0 polled first
  typedef enum logic [3:0] {
    TLIC_SRC_DBG, TLIC_SRC_EX0, TLIC_SRC_T0, TLIC_SRC_EX1, TLIC_SRC_T1,
    TLIC_SRC_U0, TLIC_SRC_T2, TLIC_SRC_SPI, TLIC_SRC_TW, TLIC_SRC_ADC,
    TLIC_SRC_PCA, TLIC_SRC_U1
  } tlic_src_e;

  typedef enum logic [1:0] {TLIC_IDLE, TLIC_REQ} tlic_phase_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tlic_bus_s;

  // Peripheral event and level inputs
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_ovf;
    logic t2_ext_evt;
    logic twowire_evt;
    logic twowire_done;
    logic adc_done;
    logic [7:0] pca_flags;
    logic [3:0] spi_flags;
    logic u0_rx;
    logic u0_tx;
    logic u1_rx;
    logic u1_tx;
    logic dbg_break;
  } tlic_periph_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] timer_control_reg;
    logic [7:0] timer2_control_reg;
    logic [7:0] ie;
    logic [7:0] irq_enable_ext_reg;
    logic [7:0] ip;
    logic [7:0] irq_priority_ext_reg;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic [2:0] ext0_sync;
    logic [2:0] ext1_sync;
    logic ext0_prev;
    logic ext1_prev;
    tlic_phase_e phase;
    logic [3:0] src;
    logic [15:0] vector;
    logic act_lo;
    logic act_hi;
  } tlic_state_s;
endpackage

//--- tlic_ctrl.sv
// Notes on behaviour
// - Each external input selects level or edge
// - External request comes from pending flag only
// - Edge pending flag clears on vectoring; level not
// - Timer 0/1 overflow flags request; timer 0 not in mode 3
// - Timer 0/1 flags clear on service
// - Timer 2 overflow requests; software clears only
// - Timer 2 external event gated by enable
// - Two-wire flag requests; hardware clears it
// - ADC requests only when its enable set
// - Counter array ORs eight flags into one
// - Serial peripheral requests on four conditions
// - UART request is rx OR tx flag
// - Second UART uses bit 4 extra registers
// - Debug breakpoint request, highest polling priority
// - One priority bit per source, 1 high
// - High preempts low; nothing preempts high
// - High level serviced before low
// - Fixed polling order within each level
// - Per-source enables plus global enable
// - Each source has fixed vector address
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "tlic_cfg.svh"
module tlic_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tlic_pkg::tlic_bus_s bus,
  output logic [7:0] rdata,
  input wire logic external_irq_input_0,
  input wire logic external_irq_input_1,
  input wire tlic_pkg::tlic_periph_s periph,
  output logic irq_req,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return
);
  tlic_pkg::tlic_state_s s_r;
  tlic_pkg::tlic_state_s s_nxt;
  logic [`TLIC_NSRC-1:0] req;
  logic [`TLIC_NSRC-1:0] pri;
  logic [`TLIC_NSRC-1:0] en;
  logic [`TLIC_NSRC-1:0] cand_hi;
  logic [`TLIC_NSRC-1:0] cand_lo;
  logic [3:0] win;
  logic win_hi;
  logic win_ok;
  logic ext0_lvl;
  logic ext1_lvl;
  logic timer_control_reg_wr;

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0: vec_of = `TLIC_VEC_DBG;
      4'h1: vec_of = `TLIC_VEC_EX0;
      4'h2: vec_of = `TLIC_VEC_T0;
      4'h3: vec_of = `TLIC_VEC_EX1;
      4'h4: vec_of = `TLIC_VEC_T1;
      4'h5: vec_of = `TLIC_VEC_U0;
      4'h6: vec_of = `TLIC_VEC_T2;
      4'h7: vec_of = `TLIC_VEC_SPI;
      4'h8: vec_of = `TLIC_VEC_TW;
      4'h9: vec_of = `TLIC_VEC_ADC;
      4'hA: vec_of = `TLIC_VEC_PCA;
      default: vec_of = `TLIC_VEC_U1;
    endcase
  endfunction

  // Lowest set index wins, matching the polling order
  function automatic logic [3:0] first_set(input logic [`TLIC_NSRC-1:0] v);
    first_set = 4'h0;
    for (int i = `TLIC_NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
        first_set = 4'(i);
    end
  endfunction

  // Enable and priority bits rearranged into polling order
  function automatic logic [`TLIC_NSRC-1:0] src_map(input logic [7:0] base,
    input logic [7:0] ext);
    src_map[0] = base[6];
    src_map[1] = base[0];
    src_map[2] = base[1];
    src_map[3] = base[2];
    src_map[4] = base[3];
    src_map[5] = base[4];
    src_map[6] = base[5];
    src_map[7] = ext[6];
    src_map[8] = ext[1];
    src_map[9] = ext[7];
    src_map[10] = ext[5];
    src_map[11] = ext[4];
  endfunction

  // Active-low pin: a change counts only once stages two and three agree
  function automatic logic pin_level(input logic [2:0] sync, input logic held);
    pin_level = (sync[1] == sync[2]) ? ~sync[2] : held;
  endfunction

  // Next pending flag of one external input; a hardware set beats a software write
  function automatic logic ext_pend(input logic cur, input logic edge_mode,
    input logic lvl, input logic prev, input logic sw_wr);
    ext_pend = cur;
    if (edge_mode ? (lvl & ~prev) : lvl)
      ext_pend = 1'b1;
    else if (!edge_mode && !lvl && !sw_wr)
      ext_pend = 1'b0;
  endfunction

  // The held level doubles as the edge detector's previous value
  assign ext0_lvl = pin_level(s_r.ext0_sync, s_r.ext0_prev);
  assign ext1_lvl = pin_level(s_r.ext1_sync, s_r.ext1_prev);
  assign timer_control_reg_wr = bus.wr && (bus.addr == `TLIC_OFS_TIMER_CONTROL_REG);

  always_comb
  begin
    // Pending flags, not the pins, feed the arbiter
    req[0] = s_r.flags[`TLIC_FL_DBG];
    req[1] = s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE0];
    req[2] = s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF0] & ~s_r.ctrl[`TLIC_CTRL_T0M3];
    req[3] = s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE1];
    req[4] = s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF1];
    req[5] = periph.u0_rx | periph.u0_tx;
    req[6] = s_r.timer2_control_reg[`TLIC_T2_TF2] | s_r.timer2_control_reg[`TLIC_T2_TIMER2_EXT_EVENT_FLAG];
    req[7] = |periph.spi_flags;
    req[8] = s_r.flags[`TLIC_FL_TW];
    req[9] = s_r.flags[`TLIC_FL_ADC];
    req[10] = |periph.pca_flags;
    req[11] = periph.u1_rx | periph.u1_tx;
    en = src_map(s_r.ie, s_r.irq_enable_ext_reg);
    pri = src_map(s_r.ip, s_r.irq_priority_ext_reg);
    cand_hi = req & en & pri;
    cand_lo = req & en & ~pri;
    // High level first; a low routine blocks only lows, a high one blocks all
    win_hi = |cand_hi;
    win = win_hi ? first_set(cand_hi) : first_set(cand_lo);
    win_ok = s_r.ie[`TLIC_IE_EA] & ~s_r.act_hi &
             (win_hi | ((|cand_lo) & ~s_r.act_lo));
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ext0_sync = {s_r.ext0_sync[1:0], external_irq_input_0};
    s_nxt.ext1_sync = {s_r.ext1_sync[1:0], external_irq_input_1};
    s_nxt.ext0_prev = ext0_lvl;
    s_nxt.ext1_prev = ext1_lvl;
    s_nxt.rdata = `TLIC_RST_BYTE;

    // Software writes first so that hardware sets below win over clears
    if (bus.wr)
    begin
      case (bus.addr)
        `TLIC_OFS_TIMER_CONTROL_REG: s_nxt.timer_control_reg = bus.wdata;
        `TLIC_OFS_TIMER2_CONTROL_REG: s_nxt.timer2_control_reg = bus.wdata;
        `TLIC_OFS_IE: s_nxt.ie = bus.wdata;
        `TLIC_OFS_IEA: s_nxt.irq_enable_ext_reg = bus.wdata & 8'hF2;
        `TLIC_OFS_IP: s_nxt.ip = bus.wdata & 8'h7F;
        `TLIC_OFS_IPA: s_nxt.irq_priority_ext_reg = bus.wdata & 8'hF2;
        `TLIC_OFS_FLCLR: s_nxt.flags = s_r.flags & ~bus.wdata;
        `TLIC_OFS_CTRL: s_nxt.ctrl = bus.wdata & 8'h01;
        default: ;
      endcase
    end
    if (bus.rd)
    begin
      case (bus.addr)
        `TLIC_OFS_TIMER_CONTROL_REG: s_nxt.rdata = s_r.timer_control_reg;
        `TLIC_OFS_TIMER2_CONTROL_REG: s_nxt.rdata = s_r.timer2_control_reg;
        `TLIC_OFS_IE: s_nxt.rdata = s_r.ie;
        `TLIC_OFS_IEA: s_nxt.rdata = s_r.irq_enable_ext_reg;
        `TLIC_OFS_IP: s_nxt.rdata = s_r.ip;
        `TLIC_OFS_IPA: s_nxt.rdata = s_r.irq_priority_ext_reg;
        `TLIC_OFS_FLAGS: s_nxt.rdata = s_r.flags;
        `TLIC_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
        default: s_nxt.rdata = `TLIC_RST_BYTE;
      endcase
    end

    // Vectoring: hardware clears tied to the acknowledge
    if (s_r.phase == tlic_pkg::TLIC_REQ && irq_ack)
    begin
      if (s_r.src == 4'h1 && s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IT0])
        s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE0] = 1'b0;
      if (s_r.src == 4'h3 && s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IT1])
        s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE1] = 1'b0;
      if (s_r.src == 4'h2)
        s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF0] = 1'b0;
      if (s_r.src == 4'h4)
        s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF1] = 1'b0;
    end
    // Two-wire controller ends its own request when it is done
    if (periph.twowire_done)
      s_nxt.flags[`TLIC_FL_TW] = 1'b0;

    // Level mode follows the pin, so the source must release it in time
    s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE0] = ext_pend(s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE0], s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IT0],
      ext0_lvl, s_r.ext0_prev, timer_control_reg_wr);
    s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE1] = ext_pend(s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IE1], s_r.timer_control_reg[`TLIC_TIMER_CONTROL_REG_IT1],
      ext1_lvl, s_r.ext1_prev, timer_control_reg_wr);
    if (periph.t0_ovf)
      s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF0] = 1'b1;
    if (periph.t1_ovf)
      s_nxt.timer_control_reg[`TLIC_TIMER_CONTROL_REG_TF1] = 1'b1;
    if (periph.t2_ovf)
      s_nxt.timer2_control_reg[`TLIC_T2_TF2] = 1'b1;
    if (periph.t2_ext_evt && s_r.timer2_control_reg[`TLIC_T2_TIMER2_EXT_EVENT_ENABLE])
      s_nxt.timer2_control_reg[`TLIC_T2_TIMER2_EXT_EVENT_FLAG] = 1'b1;
    if (periph.twowire_evt)
      s_nxt.flags[`TLIC_FL_TW] = 1'b1;
    if (periph.adc_done)
      s_nxt.flags[`TLIC_FL_ADC] = 1'b1;
    if (periph.dbg_break)
      s_nxt.flags[`TLIC_FL_DBG] = 1'b1;

    // Request handshake and nesting record
    unique case (s_r.phase)
      tlic_pkg::TLIC_IDLE:
      begin
        if (win_ok)
        begin
          s_nxt.phase = tlic_pkg::TLIC_REQ;
          s_nxt.src = win;
          s_nxt.vector = vec_of(win);
        end
      end
      tlic_pkg::TLIC_REQ:
      begin
        if (irq_ack)
        begin
          s_nxt.phase = tlic_pkg::TLIC_IDLE;
          if (pri[s_r.src])
            s_nxt.act_hi = 1'b1;
          else
            s_nxt.act_lo = 1'b1;
        end
        else if (!win_ok)
          s_nxt.phase = tlic_pkg::TLIC_IDLE;
        else
        begin
          // Track a better winner until the core takes one
          s_nxt.src = win;
          s_nxt.vector = vec_of(win);
        end
      end
      default: s_nxt.phase = tlic_pkg::TLIC_IDLE;
    endcase
    // Return ends the innermost routine: high level first
    if (irq_return)
    begin
      if (s_r.act_hi)
        s_nxt.act_hi = 1'b0;
      else
        s_nxt.act_lo = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.ext0_sync <= 3'h7;
      s_r.ext1_sync <= 3'h7;
      s_r.phase <= tlic_pkg::TLIC_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;
  assign irq_req = (s_r.phase == tlic_pkg::TLIC_REQ);
  assign irq_vector = s_r.vector;
endmodule

//--- tlic_chk.sv
`timescale 1ns/100ps
module tlic_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tlic_pkg::tlic_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic irq_ack
);
  // Shadows of the software-only registers, so reads can be predicted
  logic [7:0] ie_r, iea_r, ip_r, ipa_r;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ie_r <= 8'h00;
      iea_r <= 8'h00;
      ip_r <= 8'h00;
      ipa_r <= 8'h00;
    end
    else if (bus.wr)
    begin
      if (bus.addr == 8'hA8) ie_r <= bus.wdata;
      if (bus.addr == 8'hA7) iea_r <= bus.wdata;
      if (bus.addr == 8'hB8) ip_r <= bus.wdata;
      if (bus.addr == 8'hB7) ipa_r <= bus.wdata;
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ack_drop;
    irq_req && irq_ack |=> !irq_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_vec;
    irq_req |-> irq_vector inside {16'h0063, 16'h0003, 16'h000B, 16'h0013, 16'h001B,
      16'h0023, 16'h002B, 16'h0053, 16'h0043, 16'h003B, 16'h005B, 16'h004B};
  endproperty
  a_vec: assert property (p_vec) else $error("unknown vector");
  property p_ga;
    !ie_r[7] && !$past(ie_r[7]) |-> !irq_req;
  endproperty
  a_ga: assert property (p_ga) else $error("request while globally off");
  property p_rd_ie;
    bus.rd && bus.addr == 8'hA8 |=> rdata == $past(ie_r);
  endproperty
  a_rd_ie: assert property (p_rd_ie) else $error("enable readback");
  property p_rd_iea;
    bus.rd && bus.addr == 8'hA7 |=> rdata == ($past(iea_r) & 8'hF2);
  endproperty
  a_rd_iea: assert property (p_rd_iea) else $error("enable2 readback");
  property p_rd_ip;
    bus.rd && bus.addr == 8'hB8 |=> rdata == ($past(ip_r) & 8'h7F);
  endproperty
  a_rd_ip: assert property (p_rd_ip) else $error("priority readback");
  property p_rd_ipa;
    bus.rd && bus.addr == 8'hB7 |=> rdata == ($past(ipa_r) & 8'hF2);
  endproperty
  a_rd_ipa: assert property (p_rd_ipa) else $error("priority2 readback");
  property p_dbg;
    irq_req && irq_vector == 16'h0063 && !irq_ack && !bus.wr && ie_r[7] && ip_r[6]
      |=> irq_req && irq_vector == 16'h0063;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug request lost");
endmodule

//--- tlic_core_model.sv
`timescale 1ns/100ps
module tlic_core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  output logic irq_return,
  output int n_ack,
  output logic [15:0] last_vec
);
  int wt, dp;
  int left[2];
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      {irq_ack, irq_return, last_vec} <= '0;
      {n_ack, wt, dp} <= '0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      wt <= irq_req ? wt + 1 : 0;
      // Only the innermost routine runs; an outer one is frozen
      if (dp > 0) left[dp - 1] <= left[dp - 1] - 1;
      if (irq_ack && irq_req)
      begin
        n_ack <= n_ack + 1;
        last_vec <= irq_vector;
        left[dp] <= 30;
        dp <= dp + 1;
        wt <= 0;
      end
      else if (dp > 0 && left[dp - 1] <= 1)
      begin
        irq_return <= 1'b1;
        dp <= dp - 1;
      end
      else if (irq_req && !irq_ack && wt >= (slow ? 4 : 0))
        irq_ack <= 1'b1;
    end
endmodule

//--- two_level_interrupt_controller_bench.sv
`timescale 1ns/100ps
module two_level_interrupt_controller_bench;
  localparam logic [15:0] VEC[12] = '{16'h0063, 16'h0003, 16'h000B, 16'h0013, 16'h001B,
    16'h0023, 16'h002B, 16'h0053, 16'h0043, 16'h003B, 16'h005B, 16'h004B};
  localparam logic [7:0] CA[12] = '{8'hF0, 8'h88, 8'h88, 8'h88, 8'h88, 8'h00, 8'hC8, 8'h00,
    8'hF0, 8'hF0, 8'h00, 8'h00};
  localparam logic [7:0] CV[12] = '{8'h01, 8'h02, 8'h00, 8'h08, 8'h00, 8'h00, 8'h88, 8'h00,
    8'h04, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] RA[9] = '{8'h88, 8'hA8, 8'hA7, 8'hB8, 8'hB7, 8'hC8, 8'hF0, 8'hF2, 8'h55};
  localparam logic [7:0] WM[5] = '{8'h00, 8'hFF, 8'hF2, 8'h7F, 8'hF2};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [1:0] ext_n = 2'b11;
  tlic_pkg::tlic_bus_s bus = '0;
  tlic_pkg::tlic_periph_s periph = '0;
  logic [7:0] rdata, r;
  logic irq_req, irq_ack, irq_return;
  logic [15:0] irq_vector, last_vec;
  int n_ack;
  int fails = 0;
  int n_tests = 0;
  always #20 clk_sys = ~clk_sys;
  tlic_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .external_irq_input_0(ext_n[0]), .external_irq_input_1(ext_n[1]), .periph(periph),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return));
  tlic_core_model core (.clk_sys(clk_sys), .rst(rst), .slow(slow), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return), .n_ack(n_ack),
    .last_vec(last_vec));
  task automatic check(string what, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    check("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic cfg(logic [7:0] en, logic [7:0] en2, logic [7:0] hi);
    wr(8'hA8, en);
    wr(8'hA7, en2);
    wr(8'hB8, hi);
  endtask
  // Bit order of m follows the polling order; bit 12 is the timer 2 pin event
  task automatic fire(logic [12:0] m);
    r = 8'($urandom);
    @(posedge clk_sys);
    periph.dbg_break <= m[0];
    ext_n <= ~{m[3], m[1]};
    periph.t0_ovf <= m[2];
    periph.t1_ovf <= m[4];
    {periph.u0_rx, periph.u0_tx} <= m[5] ? 2'(2'b01 << r[0]) : 2'b00;
    periph.t2_ovf <= m[6];
    periph.spi_flags <= m[7] ? 4'(4'h1 << r[2:1]) : 4'h0;
    periph.twowire_evt <= m[8];
    periph.adc_done <= m[9];
    periph.pca_flags <= m[10] ? 8'(8'h01 << r[5:3]) : 8'h00;
    {periph.u1_rx, periph.u1_tx} <= m[11] ? 2'(2'b01 << r[6]) : 2'b00;
    periph.t2_ext_evt <= m[12];
    @(posedge clk_sys);
    {periph.dbg_break, periph.t0_ovf, periph.t1_ovf, periph.t2_ovf} <= 4'h0;
    {periph.twowire_evt, periph.adc_done, periph.t2_ext_evt} <= 3'h0;
  endtask
  // Sources drop well before the 30-cycle routine returns
  task automatic clr;
    fire(13'h0000);
    wr(8'h88, 8'h00);
    wr(8'hC8, 8'h08);
    // Two-wire flag is left to the controller's own clear, so that clear is checked
    wr(8'hF1, 8'h03);
    periph.twowire_done <= 1'b1;
    @(posedge clk_sys);
    periph.twowire_done <= 1'b0;
    repeat (70) @(posedge clk_sys);
  endtask
  // A zero vector means no acknowledge is expected within the limit
  task automatic want(logic [15:0] v, int lim);
    int b;
    b = n_ack;
    for (int k = 0; k < lim && n_ack == b; k++) @(posedge clk_sys);
    @(negedge clk_sys);
    check("vector", v, n_ack == b ? 16'h0000 : last_vec);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h2C24));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (RA[i]) rd(RA[i], 8'h00);
    for (int i = 1; i < 5; i++)
    begin
      wr(RA[i], 8'($urandom));
      rd(RA[i], bus.wdata & WM[i]);
    end
    $display("test registers done");
    clr();
    for (int i = 0; i < 12; i++)
    begin
      slow <= (i == 0) | 1'($urandom);
      cfg(8'hFF, 8'hFF, 8'hFF);
      fire(13'(1 << i));
      want(VEC[i], 40);
      rd(CA[i], CV[i]);
      clr();
      rd(8'hF0, 8'h00);
    end
    $display("test sources done");
    wr(8'h88, 8'h05);
    cfg(8'h85, 8'h00, 8'h00);
    fire(13'h000A);
    fire(13'h0000);
    want(16'h0003, 40);
    rd(8'h88, 8'h0D);
    want(16'h0013, 80);
    rd(8'h88, 8'h05);
    clr();
    cfg(8'h02, 8'h00, 8'h00);
    fire(13'h0004);
    want(16'h0000, 20);
    wr(8'hA8, 8'h82);
    want(16'h000B, 20);
    clr();
    cfg(8'hFF, 8'h7F, 8'h00);
    fire(13'h0200);
    want(16'h0000, 20);
    rd(8'hF0, 8'h02);
    clr();
    wr(8'hF2, 8'h01);
    fire(13'h0004);
    want(16'h0000, 20);
    wr(8'hF2, 8'h00);
    clr();
    wr(8'hC8, 8'h00);
    fire(13'h1000);
    want(16'h0000, 20);
    wr(8'hC8, 8'h08);
    fire(13'h1000);
    want(16'h002B, 40);
    clr();
    $display("test gating done");
    fire(13'h0014);
    want(16'h000B, 40);
    want(16'h001B, 80);
    clr();
    cfg(8'hFF, 8'h00, 8'h08);
    fire(13'h0014);
    want(16'h001B, 40);
    want(16'h000B, 80);
    clr();
    cfg(8'hFF, 8'h00, 8'h42);
    fire(13'h0010);
    want(16'h001B, 40);
    fire(13'h0004);
    want(16'h000B, 12);
    fire(13'h0001);
    want(16'h0000, 12);
    want(16'h0063, 80);
    clr();
    $display("test priority done");
    stop_test();
  end
  initial
  begin
    #(40 * 20000);
    fails++;
    stop_test();
  end
endmodule
bind tlic_ctrl tlic_chk chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack));
